/* File: rsu_pkg.sv */
package rsu_pkg;
  localparam int RSU_AW = 8;
  localparam int RSU_DW = 32;
  localparam int RSU_DATA_BITS = 8;
  localparam int RSU_DIV_W = 16;
  localparam int RSU_BIT_CNT_W = 3;
  localparam int RSU_NEV = 4;
  // register indexes; byte address is four times the index
  localparam int RSU_IDX_DATA = 0;
  localparam int RSU_IDX_CTRL = 4;
  localparam int RSU_IDX_STAT = 5;
  localparam int RSU_IDX_ISTAT = 6;
  localparam int RSU_IDX_IMASK = 7;
  localparam int RSU_IDX_DIV = 8;
  localparam logic [RSU_AW-1:0] RSU_ADDR_DATA = RSU_AW'(RSU_IDX_DATA * 4);
  localparam logic [RSU_AW-1:0] RSU_ADDR_CTRL = RSU_AW'(RSU_IDX_CTRL * 4);
  localparam logic [RSU_AW-1:0] RSU_ADDR_STAT = RSU_AW'(RSU_IDX_STAT * 4);
  localparam logic [RSU_AW-1:0] RSU_ADDR_ISTAT = RSU_AW'(RSU_IDX_ISTAT * 4);
  localparam logic [RSU_AW-1:0] RSU_ADDR_IMASK = RSU_AW'(RSU_IDX_IMASK * 4);
  localparam logic [RSU_AW-1:0] RSU_ADDR_DIV = RSU_AW'(RSU_IDX_DIV * 4);
  // field positions
  localparam int RSU_CTRL_DRV_BIT = 0;
  localparam int RSU_STAT_RXRDY_BIT = 0;
  localparam int RSU_STAT_OVR_BIT = 1;
  localparam int RSU_STAT_HOLD_BIT = 5;
  localparam int RSU_STAT_SHIFT_BIT = 6;
  localparam int RSU_EV_HOLD_EMPTY = 0;
  localparam int RSU_EV_TX_DONE = 1;
  localparam int RSU_EV_RX_READY = 2;
  localparam int RSU_EV_RX_OVR = 3;
  // reset values
  localparam logic [RSU_DATA_BITS-1:0] RSU_CTRL_RESET = 8'h00;
  localparam logic [RSU_NEV-1:0] RSU_IMASK_RESET = 4'h0;
  // bit timing from core clock and default baud rate
  localparam int RSU_CLK_HZ = 40_000_000;
  localparam int RSU_BAUD = 9600;
  localparam logic [RSU_DIV_W-1:0] RSU_DIV_RESET = RSU_DIV_W'(RSU_CLK_HZ / RSU_BAUD);
  localparam logic [RSU_DIV_W-1:0] RSU_DIV_MIN = 16'h0002;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} rsu_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rsu_rx_state_t;
endpackage

/* File: rsu_tx_shift.sv */
`timescale 1ns/1ps
module rsu_tx_shift (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic [rsu_pkg::RSU_DATA_BITS-1:0] i_data,
  input wire logic [rsu_pkg::RSU_DIV_W-1:0] i_divisor,
  output logic o_txd,
  output logic o_hold_busy,
  output logic o_shift_busy,
  output logic o_done
);
  import rsu_pkg::*;
  rsu_tx_state_t state;
  logic [RSU_DATA_BITS-1:0] hold;
  logic [RSU_DATA_BITS-1:0] shifter;
  logic [RSU_DIV_W-1:0] cnt;
  logic [RSU_BIT_CNT_W-1:0] bit_idx;
  logic tick;
  logic take;

  assign tick = (cnt == '0);
  assign take = (state == TX_IDLE) && o_hold_busy;
  assign o_shift_busy = (state != TX_IDLE);

  // holding register; a load while full is dropped
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold <= '0;
      o_hold_busy <= 1'h0;
    end else if (i_load && !o_hold_busy) begin
      hold <= i_data;
      o_hold_busy <= 1'h1;
    end else if (take) begin
      o_hold_busy <= 1'h0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= TX_IDLE;
      shifter <= '0;
      cnt <= '0;
      bit_idx <= '0;
      o_txd <= 1'h1;
      o_done <= 1'h0;
    end else begin
      o_done <= 1'h0;
      cnt <= tick ? i_divisor - 1'h1 : cnt - 1'h1;
      unique case (state)
        TX_IDLE: begin
          if (take) begin
            shifter <= hold;
            cnt <= i_divisor - 1'h1;
            o_txd <= 1'h0;
            state <= TX_START;
          end
        end
        TX_START: begin
          if (tick) begin
            o_txd <= shifter[0];
            bit_idx <= '0;
            state <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tick) begin
            if (bit_idx == RSU_BIT_CNT_W'(RSU_DATA_BITS - 1)) begin
              o_txd <= 1'h1;
              state <= TX_STOP;
            end else begin
              o_txd <= shifter[bit_idx + 1'h1];
              bit_idx <= bit_idx + 1'h1;
            end
          end
        end
        TX_STOP: begin
          if (tick) begin
            o_done <= 1'h1;
            state <= TX_IDLE;
          end
        end
      endcase
    end
  end
endmodule

/* File: rsu_uart_top.sv */
`timescale 1ns/1ps
module rsu_uart_top (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [rsu_pkg::RSU_AW-1:0] i_paddr,
  input wire logic [rsu_pkg::RSU_DW-1:0] i_pwdata,
  output logic [rsu_pkg::RSU_DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_line_driver_enable,
  output logic o_irq
);
  import rsu_pkg::*;

  logic [RSU_DATA_BITS-1:0] ctrl_reg;
  logic [RSU_DIV_W-1:0] divisor;
  logic [RSU_NEV-1:0] istat;
  logic [RSU_NEV-1:0] imask;
  logic [RSU_NEV-1:0] events;
  logic [RSU_DW-1:0] next_prdata;
  logic next_pslverr;
  logic access;
  logic commit;
  logic wr_data;
  logic wr_ctrl;
  logic wr_istat;
  logic wr_imask;
  logic wr_div;
  logic rd_data;
  logic hold_busy;
  logic shift_busy;
  logic hold_busy_d;
  logic tx_done;
  logic tx_txd;
  rsu_rx_state_t rx_state;
  logic [RSU_DIV_W-1:0] rx_cnt;
  logic [RSU_BIT_CNT_W-1:0] rx_idx;
  logic [RSU_DATA_BITS-1:0] rx_shift;
  logic [RSU_DATA_BITS-1:0] rx_buf;
  logic rx_ready;
  logic rx_ovr;
  logic rx_done;
  logic rx_tick;

  assign access = i_psel && i_penable;
  assign commit = access && o_pready;
  assign wr_data = commit && i_pwrite && (i_paddr == RSU_ADDR_DATA);
  assign wr_ctrl = commit && i_pwrite && (i_paddr == RSU_ADDR_CTRL);
  assign wr_istat = commit && i_pwrite && (i_paddr == RSU_ADDR_ISTAT);
  assign wr_imask = commit && i_pwrite && (i_paddr == RSU_ADDR_IMASK);
  assign wr_div = commit && i_pwrite && (i_paddr == RSU_ADDR_DIV);
  assign rd_data = commit && !i_pwrite && (i_paddr == RSU_ADDR_DATA);

  // read mux; unmapped addresses answer with an error
  always_comb begin
    next_prdata = '0;
    next_pslverr = 1'h0;
    case (i_paddr)
      RSU_ADDR_DATA: next_prdata[RSU_DATA_BITS-1:0] = rx_buf;
      RSU_ADDR_CTRL: next_prdata[RSU_DATA_BITS-1:0] = ctrl_reg;
      RSU_ADDR_STAT: begin
        next_prdata[RSU_STAT_RXRDY_BIT] = rx_ready;
        next_prdata[RSU_STAT_OVR_BIT] = rx_ovr;
        next_prdata[RSU_STAT_HOLD_BIT] = hold_busy;
        next_prdata[RSU_STAT_SHIFT_BIT] = shift_busy;
      end
      RSU_ADDR_ISTAT: next_prdata[RSU_NEV-1:0] = istat;
      RSU_ADDR_IMASK: next_prdata[RSU_NEV-1:0] = imask;
      RSU_ADDR_DIV: next_prdata[RSU_DIV_W-1:0] = divisor;
      default: next_pslverr = 1'h1;
    endcase
  end

  // one wait state, answer registered
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready <= 1'h0;
      o_prdata <= '0;
      o_pslverr <= 1'h0;
    end else begin
      o_pready <= access && !o_pready;
      if (access && !o_pready) begin
        o_prdata <= i_pwrite ? '0 : next_prdata;
        o_pslverr <= next_pslverr;
      end else begin
        o_pslverr <= 1'h0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_reg <= RSU_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= i_pwdata[RSU_DATA_BITS-1:0];
    end
  end

  assign o_line_driver_enable = ctrl_reg[RSU_CTRL_DRV_BIT];

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      divisor <= RSU_DIV_RESET;
    end else if (wr_div && i_pwdata[RSU_DIV_W-1:0] >= RSU_DIV_MIN) begin
      divisor <= i_pwdata[RSU_DIV_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      imask <= RSU_IMASK_RESET;
    end else if (wr_imask) begin
      imask <= i_pwdata[RSU_NEV-1:0];
    end
  end

  rsu_tx_shift u_tx (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_load(wr_data),
    .i_data(i_pwdata[RSU_DATA_BITS-1:0]),
    .i_divisor(divisor),
    .o_txd(tx_txd),
    .o_hold_busy(hold_busy),
    .o_shift_busy(shift_busy),
    .o_done(tx_done)
  );
  assign o_txd = tx_txd;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_busy_d <= 1'h0;
    end else begin
      hold_busy_d <= hold_busy;
    end
  end

  assign rx_tick = (rx_cnt == '0);
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_shift <= '0;
      rx_done <= 1'h0;
    end else begin
      rx_done <= 1'h0;
      rx_cnt <= rx_tick ? divisor - 1'h1 : rx_cnt - 1'h1;
      unique case (rx_state)
        RX_IDLE: begin
          if (!i_rxd) begin
            rx_cnt <= {1'h0, divisor[RSU_DIV_W-1:1]};
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_idx <= '0;
            rx_state <= i_rxd ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_shift <= {i_rxd, rx_shift[RSU_DATA_BITS-1:1]};
            rx_idx <= rx_idx + 1'h1;
            if (rx_idx == RSU_BIT_CNT_W'(RSU_DATA_BITS - 1)) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_done <= i_rxd;
            rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // receive buffer; a new character beats a simultaneous read
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_buf <= '0;
      rx_ready <= 1'h0;
      rx_ovr <= 1'h0;
    end else begin
      if (rx_done) begin
        rx_buf <= rx_shift;
        rx_ready <= 1'h1;
        rx_ovr <= rx_ovr || (rx_ready && !rd_data);
      end else if (rd_data) begin
        rx_ready <= 1'h0;
        rx_ovr <= 1'h0;
      end
    end
  end

  assign events[RSU_EV_HOLD_EMPTY] = hold_busy_d && !hold_busy;
  assign events[RSU_EV_TX_DONE] = tx_done;
  assign events[RSU_EV_RX_READY] = rx_done;
  assign events[RSU_EV_RX_OVR] = rx_done && rx_ready && !rd_data;

  // sticky status, write one to clear, event wins
  for (genvar g = 0; g < RSU_NEV; g++) begin : g_ev
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        istat[g] <= 1'h0;
      end else if (events[g]) begin
        istat[g] <= 1'h1;
      end else if (wr_istat && i_pwdata[g]) begin
        istat[g] <= 1'h0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'h0;
    end else begin
      o_irq <= |(istat & imask);
    end
  end

  AST_DRV_ON_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    wr_ctrl && i_pwdata[RSU_CTRL_DRV_BIT] |=> o_line_driver_enable [*2])
    else $error("driver enable not set by control write");

  AST_DRV_ROSE_CAUSE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(o_line_driver_enable) |-> $past(wr_ctrl && i_pwdata[RSU_CTRL_DRV_BIT]))
    else $error("driver enable rose without a control write");

  AST_DRV_STABLE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !$past(wr_ctrl) |-> $stable(o_line_driver_enable))
    else $error("driver enable moved without a control write");

  AST_TX_START: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    wr_data && !hold_busy && !shift_busy |=> hold_busy ##[1:2] (shift_busy && !o_txd))
    else $error("data write did not start a character");

  AST_HOLD_FLAG: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    access && !o_pready && !i_pwrite && i_paddr == RSU_ADDR_STAT
    |=> o_prdata[RSU_STAT_HOLD_BIT] == $past(hold_busy))
    else $error("holding flag misreported");

  AST_SHIFT_FLAG: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    access && !o_pready && !i_pwrite && i_paddr == RSU_ADDR_STAT
    |=> o_prdata[RSU_STAT_SHIFT_BIT] == $past(shift_busy))
    else $error("shifter flag misreported");

  AST_RX_READY: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    rx_done |=> rx_ready && rx_buf == $past(rx_shift))
    else $error("received character not buffered");

  AST_DRV_OFF_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    wr_ctrl && !i_pwdata[RSU_CTRL_DRV_BIT] |=> !o_line_driver_enable)
    else $error("driver enable not cleared by control write");

  AST_TXD_IDLE_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !shift_busy |-> o_txd)
    else $error("line not idle high between characters");

  AST_HOLD_TO_SHIFT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    hold_busy && !shift_busy |=> !hold_busy && shift_busy)
    else $error("holding register not moved into idle shifter");

  AST_SHIFT_FRAME: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(shift_busy) |-> shift_busy [*8])
    else $error("shifter busy flag dropped inside a frame");

  AST_DONE_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    tx_done |-> !shift_busy)
    else $error("character done while shifter still busy");

  AST_RX_POP: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    rd_data && !rx_done |=> !rx_ready)
    else $error("receive buffer read did not clear ready");

  AST_RX_OVERRUN: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    rx_done && rx_ready && !rd_data |=> rx_ovr)
    else $error("overrun not flagged");

  AST_PREADY_PULSE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_pready |=> !o_pready)
    else $error("ready held longer than one cycle");

  COV_TX_WITH_DRIVER: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_line_driver_enable && tx_done);
  COV_RX_CHAR: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) rx_done);
  COV_IRQ: cover property (@(posedge i_core_clk) disable iff (!i_reset_n) $rose(o_irq));
  COV_BLOCK_TX: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_line_driver_enable && hold_busy && shift_busy);
  COV_RX_OVERRUN: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
    events[RSU_EV_RX_OVR]);
endmodule

/* File: rsu_line_node.sv */
`timescale 1ns/1ps
module rsu_line_node #(parameter int BIT = 16) (
  input wire logic i_clk,
  input wire logic i_txd,
  input wire logic i_de,
  output logic o_rxd
);
  logic [7:0] got[$];
  logic [7:0] b;
  int undriven = 0;
  int frame_err = 0;
  initial o_rxd = 1'h1;
  // frames reach the bus only with driver on
  always begin
    @(negedge i_txd);
    repeat (BIT / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_clk);
      b[i] = i_txd;
    end
    repeat (BIT) @(posedge i_clk);
    if (i_txd !== 1'h1) frame_err++;
    if (i_de === 1'h1) got.push_back(b);
    else undriven++;
  end
  // remote node sends 8N1, lsb first, idle high
  task automatic send(input logic [7:0] d);
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_rxd <= (i == 0) ? 1'h0 : (i == 9) ? 1'h1 : d[i-1];
      repeat (BIT - 1) @(posedge i_clk);
    end
  endtask
endmodule

/* File: rs485_transmit_enable_uart_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH at %0t: got %0h expected %0h", $time, (g), (e)); end end
module rs485_transmit_enable_uart_tb;
  import rsu_pkg::*;
  localparam int BIT = 16;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [RSU_AW-1:0] paddr = '0;
  logic [RSU_DW-1:0] pwdata = '0;
  logic [RSU_DW-1:0] prdata, rdata;
  logic pready, pslverr, rerr, rxd, txd, de, irq;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  rsu_uart_top uut (.i_core_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .o_txd(txd),
    .o_line_driver_enable(de), .o_irq(irq));
  rsu_line_node #(.BIT(BIT)) line (.i_clk(clk), .i_txd(txd), .i_de(de), .o_rxd(rxd));
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic xfer(input logic w, input logic [RSU_AW-1:0] a, input logic [RSU_DW-1:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic poll(input logic [RSU_AW-1:0] a, input logic [RSU_DW-1:0] m,
                      input logic [RSU_DW-1:0] v);
    int n;
    n = 0;
    do begin
      xfer(1'h0, a, '0);
      n++;
    end while ((rdata & m) !== v && n < 500);
    `CHK(rdata & m, v)
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    `CHK(txd, 1'h1)
    `CHK(de, 1'h0)
    `CHK(irq, 1'h0)
    xfer(1'h0, RSU_ADDR_CTRL, '0);
    `CHK(rdata[7:0], RSU_CTRL_RESET)
    xfer(1'h0, RSU_ADDR_STAT, '0);
    `CHK(rdata[6:5], 2'h0)
    xfer(1'h1, RSU_ADDR_IMASK, 32'hF);
    xfer(1'h1, RSU_ADDR_DIV, 32'(BIT));
    xfer(1'h1, RSU_ADDR_DIV, 32'h1);
    xfer(1'h0, RSU_ADDR_DIV, '0);
    `CHK(rdata, 32'(BIT))
    xfer(1'h1, RSU_ADDR_CTRL, 32'h0);
    xfer(1'h1, RSU_ADDR_CTRL, 32'h1);
    @(negedge clk);
    `CHK(de, 1'h1)
    xfer(1'h1, RSU_ADDR_DATA, 32'h5A);
    xfer(1'h0, RSU_ADDR_STAT, '0);
    `CHK(rdata[6:5], 2'h2)
    xfer(1'h1, RSU_ADDR_DATA, 32'hC3);
    xfer(1'h1, RSU_ADDR_DATA, 32'hFF);
    xfer(1'h0, RSU_ADDR_STAT, '0);
    `CHK(rdata[6:5], 2'h3)
    poll(RSU_ADDR_STAT, 32'h60, 32'h0);
    `CHK(line.got.size(), 2)
    `CHK(line.got[0], 8'h5A)
    `CHK(line.got[1], 8'hC3)
    `CHK(line.frame_err, 0)
    `CHK(de, 1'h1)
    xfer(1'h1, RSU_ADDR_CTRL, 32'h0);
    @(negedge clk);
    `CHK(de, 1'h0)
    xfer(1'h1, RSU_ADDR_DATA, 32'h7E);
    poll(RSU_ADDR_STAT, 32'h60, 32'h0);
    `CHK(line.undriven, 1)
    xfer(1'h0, RSU_ADDR_ISTAT, '0);
    `CHK(rdata[1:0], 2'h3)
    `CHK(irq, 1'h1)
    xfer(1'h1, RSU_ADDR_IMASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'h0)
    xfer(1'h1, RSU_ADDR_IMASK, 32'hF);
    xfer(1'h1, RSU_ADDR_ISTAT, 32'hF);
    xfer(1'h0, RSU_ADDR_ISTAT, '0);
    `CHK(rdata[3:0], 4'h0)
    `CHK(irq, 1'h0)
    line.send(8'h96);
    poll(RSU_ADDR_STAT, 32'h1, 32'h1);
    xfer(1'h0, RSU_ADDR_DATA, '0);
    `CHK(rdata[7:0], 8'h96)
    xfer(1'h0, RSU_ADDR_STAT, '0);
    `CHK(rdata[0], 1'h0)
    xfer(1'h0, RSU_ADDR_ISTAT, '0);
    `CHK(rdata[2], 1'h1)
    `CHK(irq, 1'h1)
    line.send(8'h11);
    line.send(8'h22);
    poll(RSU_ADDR_STAT, 32'h2, 32'h2);
    xfer(1'h0, RSU_ADDR_DATA, '0);
    `CHK(rdata[7:0], 8'h22)
    xfer(1'h0, RSU_ADDR_ISTAT, '0);
    `CHK(rdata[3], 1'h1)
    xfer(1'h0, 8'h3C, '0);
    `CHK(rerr, 1'h1)
    `CHK(rdata, 32'h0)
    xfer(1'h1, 8'h3C, 32'hFFFFFFFF);
    `CHK(rerr, 1'h1)
    conclude();
  end
endmodule
